// ==== design/event_router_pkg.sv ====
// Constants and types shared by the event router design files
`default_nettype none
package event_router_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned EVT_W  = 18;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADR_W  = 12;
  localparam int unsigned SEL_W  = 4;
  localparam int unsigned IRQ_W  = 2;

  // ****************************************************************
  // Register byte offsets from the router base address
  // ****************************************************************
  localparam logic [11:0] OFS_PENDING       = 12'hC00;
  localparam logic [11:0] OFS_PENDING_CLEAR = 12'hC20;
  localparam logic [11:0] OFS_PENDING_SET   = 12'hC40;
  localparam logic [11:0] OFS_ENABLE        = 12'hC60;
  localparam logic [11:0] OFS_ENABLE_CLEAR  = 12'hC80;
  localparam logic [11:0] OFS_ENABLE_SET    = 12'hCA0;
  localparam logic [11:0] OFS_POLARITY      = 12'hCC0;
  localparam logic [11:0] OFS_TRIGGER       = 12'hCE0;
  localparam logic [11:0] OFS_RESERVED      = 12'hD00;
  localparam logic [11:0] OFS_RAW_STATUS    = 12'hD20;
  localparam logic [11:0] OFS_IRQ_STATUS    = 12'hD40;
  localparam logic [11:0] OFS_IRQ_MASK      = 12'hD60;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [17:0] RST_PENDING  = 18'h00000;
  localparam logic [17:0] RST_ENABLE   = 18'h3FFFF;
  localparam logic [17:0] RST_POLARITY = 18'h3C00F;
  localparam logic [17:0] RST_TRIGGER  = 18'h3FFFF;
  localparam logic [17:0] RST_RAW      = 18'h00000;
  localparam logic [1:0]  RST_IRQ      = 2'h0;

  // ****************************************************************
  // Block interrupt status fields
  // ****************************************************************
  localparam int unsigned IRQ_CAPTURE_BIT = 0;
  localparam int unsigned IRQ_BUS_ERR_BIT = 1;

  typedef enum {BUS_IDLE, BUS_ACK} bus_state_t;

endpackage
`default_nettype wire

// ==== design/reg_access_if.sv ====
// Register access strobes between the bus slave and the router core
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
  logic        acc_stb;
  logic        wr_stb;
  logic [11:0] adr;
  logic [31:0] wdata;
  logic [31:0] rdata;

  modport slave (output acc_stb, wr_stb, adr, wdata, input rdata);
  modport core  (input acc_stb, wr_stb, adr, wdata, output rdata);
endinterface
`default_nettype wire

// ==== design/wb_reg_slave.sv ====
// Classic single-cycle bus slave feeding the router register file
`timescale 1ns/1ns
`default_nettype none
module wb_reg_slave (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  reg_access_if.slave      rif
);

  event_router_pkg::bus_state_t state_reg;
  logic                         req;

  // ****************************************************************
  // Request decode: one access per handshake
  // ****************************************************************
  assign req         = wb_cyc_i && wb_stb_i
                    && (state_reg == event_router_pkg::BUS_IDLE);
  assign rif.acc_stb = req;
  assign rif.wr_stb  = req && wb_we_i;
  assign rif.adr     = wb_adr_i;
  // Unselected byte lanes write as zero: no set or clear, but polarity and trigger bits load zero
  assign rif.wdata   = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= event_router_pkg::BUS_IDLE;
    end else begin
      unique case (state_reg)
        event_router_pkg::BUS_IDLE: begin
          if (req) begin
            state_reg <= event_router_pkg::BUS_ACK;
          end
        end
        event_router_pkg::BUS_ACK: begin
          state_reg <= event_router_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rif.rdata;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

endmodule // wb_reg_slave
`default_nettype wire

// ==== design/event_router.sv ====
// Event router: pending and enable registers with event forwarding
//
// Operation
// - Registers decode at fixed offsets from C00h, spaced 20h apart.
// - Eighteen read-only pending bits; enabled ones request interrupts.
// - Pending bit sets on its event or a one written to pending-set.
// - Pending bit reads zero after reset, when idle, or after clear.
// - Pending-clear write clears ones' positions, leaves the rest alone.
// - Pending-set write sets ones' positions, leaves other bits alone.
// - Enable is read-only, resets all set, set by enable-set ones.
// - Enable-clear ones clear enable bits; zeros keep their value.
// - Enabled events are recorded as pending and forwarded.
// - Disabled events neither set pending nor get forwarded.
// - Bits 31 to 18 read zero; software writes them as zero.
// - Enable gates capture and forwarding; masked events still show in raw status.
// - Trigger bit one latches on edges; zero passes the level through.
// - Polarity one means high or rising; resets to 3C00Fh.
// - Latched events need a fresh edge after a clear.
// - Raw status shows unmasked events, latched included; resets zero.
`timescale 1ns/1ns
`default_nettype none
module event_router (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic [17:0] events_i,
  output var  logic        vic_req_o,
  output var  logic [17:0] event_fwd_o,
  output var  logic        irq_o
);

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  reg_access_if rif ();

  wb_reg_slave u_slave (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .rif      (rif)
  );

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic [17:0] wr_bits(input logic        stb,
                                          input logic [11:0] a,
                                          input logic [31:0] d,
                                          input logic [11:0] ofs);
    wr_bits = (stb && a == ofs) ? d[17:0] : 18'h00000;
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[4:0] == 5'h00) && (a >= event_router_pkg::OFS_PENDING)
             && (a <= event_router_pkg::OFS_IRQ_MASK);
  endfunction

  logic [17:0] pending_reg;
  logic [17:0] enable_reg;
  logic [17:0] polarity_reg;
  logic [17:0] trigger_reg;
  logic [17:0] raw_latch_reg;
  logic [17:0] active_prev_reg;
  logic [1:0]  irq_status_reg;
  logic [1:0]  irq_mask_reg;

  logic [17:0] pclr_bits;
  logic [17:0] pset_bits;
  logic [17:0] eclr_bits;
  logic [17:0] eset_bits;
  logic [17:0] active;
  logic [17:0] edge_det;
  logic [17:0] hw_capture;
  logic [17:0] lvl_drop;
  logic [17:0] raw_status;
  logic [17:0] pending_next;
  logic [17:0] enable_next;
  logic [1:0]  irq_event;
  logic [1:0]  irq_status_next;
  logic [1:0]  irq_mask_next;

  assign pclr_bits = wr_bits(rif.wr_stb, rif.adr, rif.wdata,
                             event_router_pkg::OFS_PENDING_CLEAR);
  assign pset_bits = wr_bits(rif.wr_stb, rif.adr, rif.wdata,
                             event_router_pkg::OFS_PENDING_SET);
  assign eclr_bits = wr_bits(rif.wr_stb, rif.adr, rif.wdata,
                             event_router_pkg::OFS_ENABLE_CLEAR);
  assign eset_bits = wr_bits(rif.wr_stb, rif.adr, rif.wdata,
                             event_router_pkg::OFS_ENABLE_SET);

  // ****************************************************************
  // Event conditioning
  // ****************************************************************
  assign active     = ~(events_i ^ polarity_reg);
  assign edge_det   = active & ~active_prev_reg;
  // Enable gates capture itself, not only the forwarded request
  assign hw_capture = enable_reg
                    & ((trigger_reg & edge_det)
                    | (~trigger_reg & active));
  // Level events vanish with their source unless software sets them now
  assign lvl_drop   = ~trigger_reg & ~active & ~pset_bits;
  assign raw_status = (trigger_reg & raw_latch_reg)
                    | (~trigger_reg & active);

  // Prior level starts as all active so a held input is no edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_prev_reg <= 18'h3FFFF;
    end else begin
      active_prev_reg <= active;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_latch_reg <= event_router_pkg::RST_RAW;
    end else begin
      raw_latch_reg <= (raw_latch_reg & ~pclr_bits) | (trigger_reg & edge_det);
    end
  end

  // ****************************************************************
  // Pending and enable
  // ****************************************************************
  assign pending_next = ((pending_reg & ~pclr_bits) | pset_bits | hw_capture)
                      & ~lvl_drop;
  assign enable_next  = (enable_reg & ~eclr_bits)
                      | eset_bits;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pending_reg <= event_router_pkg::RST_PENDING;
    end else begin
      pending_reg <= pending_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_reg <= event_router_pkg::RST_ENABLE;
    end else begin
      enable_reg <= enable_next;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      polarity_reg <= event_router_pkg::RST_POLARITY;
      trigger_reg  <= event_router_pkg::RST_TRIGGER;
    end else begin
      if (rif.wr_stb && rif.adr == event_router_pkg::OFS_POLARITY) begin
        polarity_reg <= rif.wdata[17:0];
      end
      if (rif.wr_stb && rif.adr == event_router_pkg::OFS_TRIGGER) begin
        trigger_reg <= rif.wdata[17:0];
      end
    end
  end

  // ****************************************************************
  // Forwarding outputs
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      vic_req_o   <= 1'b0;
      event_fwd_o <= 18'h00000;
    end else begin
      vic_req_o   <= |(pending_next & enable_next);
      event_fwd_o <= pending_next & enable_next;
    end
  end

  // ****************************************************************
  // Block interrupt: new capture and unmapped access
  // ****************************************************************
  assign irq_event[event_router_pkg::IRQ_CAPTURE_BIT] = |(hw_capture
                                                      & ~pending_reg);
  assign irq_event[event_router_pkg::IRQ_BUS_ERR_BIT] = rif.acc_stb
                                                      && !is_mapped(rif.adr);

  // Event set wins over the write-one clear in the same cycle
  assign irq_status_next = (irq_status_reg
                         & ~((rif.wr_stb
                         && rif.adr == event_router_pkg::OFS_IRQ_STATUS)
                             ? rif.wdata[1:0] : 2'h0)) | irq_event;
  assign irq_mask_next   = (rif.wr_stb
                         && rif.adr == event_router_pkg::OFS_IRQ_MASK)
                         ? rif.wdata[1:0] : irq_mask_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status_reg <= event_router_pkg::RST_IRQ;
      irq_mask_reg   <= event_router_pkg::RST_IRQ;
      irq_o          <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_mask_reg   <= irq_mask_next;
      irq_o          <= |(irq_status_next & irq_mask_next);
    end
  end

  // ****************************************************************
  // Read data; upper bits and write-only slots read zero
  // ****************************************************************
  always_comb begin
    rif.rdata = 32'h0000_0000;
    unique case (rif.adr)
      event_router_pkg::OFS_PENDING:    rif.rdata[17:0] = pending_reg;
      event_router_pkg::OFS_ENABLE:     rif.rdata[17:0] = enable_reg;
      event_router_pkg::OFS_POLARITY:   rif.rdata[17:0] = polarity_reg;
      event_router_pkg::OFS_TRIGGER:    rif.rdata[17:0] = trigger_reg;
      event_router_pkg::OFS_RAW_STATUS: rif.rdata[17:0] = raw_status;
      event_router_pkg::OFS_IRQ_STATUS: rif.rdata[1:0]  = irq_status_reg;
      event_router_pkg::OFS_IRQ_MASK:   rif.rdata[1:0]  = irq_mask_reg;
      default:                          rif.rdata       = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  logic [17:0] dis_edge;
  logic [17:0] lvl_on;
  assign dis_edge = edge_det & trigger_reg & ~enable_reg
                  & ~pending_reg & ~pset_bits;
  assign lvl_on   = ~trigger_reg & active & enable_reg;

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  property p_ack;
    s_req |=> s_ack_once;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus ack not one cycle");

  property p_pset;
    (pset_bits != 18'h00000)
      |=> ((pending_reg & $past(pset_bits)) == $past(pset_bits));
  endproperty
  a_pset: assert property (p_pset)
    else $error("pending set lost");

  property p_pclr;
    ((pclr_bits & ~pset_bits & ~hw_capture) != 18'h00000)
      |=> ((pending_reg & $past(pclr_bits & ~pset_bits & ~hw_capture))
           == 18'h00000);
  endproperty
  a_pclr: assert property (p_pclr)
    else $error("pending clear failed");

  property p_capture;
    (hw_capture != 18'h00000)
      |=> ((pending_reg & $past(hw_capture)) == $past(hw_capture));
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture lost");

  property p_cap_fwd;
    ((hw_capture & ~eclr_bits) != 18'h00000) |=> vic_req_o;
  endproperty
  a_cap_fwd: assert property (p_cap_fwd)
    else $error("capture not forwarded");

  property p_fwd_match;
    event_fwd_o == (pending_reg & enable_reg);
  endproperty
  a_fwd_match: assert property (p_fwd_match)
    else $error("forward vector mismatch");

  property p_disabled;
    (dis_edge != 18'h00000) |=> ((pending_reg & $past(dis_edge)) == 18'h00000);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("masked event pended");

  property p_en_clr;
    ((eclr_bits & ~eset_bits) != 18'h00000)
      |=> ((enable_reg & $past(eclr_bits & ~eset_bits)) == 18'h00000);
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("enable clear failed");

  property p_en_keep;
    ((eclr_bits | eset_bits) == 18'h00000) |=> $stable(enable_reg);
  endproperty
  a_en_keep: assert property (p_en_keep)
    else $error("enable changed");

  property p_no_retrig;
    (trigger_reg[0] && pclr_bits[0] && active_prev_reg[0] && active[0]
     && !pset_bits[0]) |=> !pending_reg[0];
  endproperty
  a_no_retrig: assert property (p_no_retrig)
    else $error("level retriggered");

  property p_level_drop;
    (lvl_drop != 18'h00000) |=> ((pending_reg & $past(lvl_drop)) == 18'h00000);
  endproperty
  a_level_drop: assert property (p_level_drop)
    else $error("level bit held");

  property p_level_cap;
    (lvl_on != 18'h00000) |=> ((pending_reg & $past(lvl_on)) == $past(lvl_on));
  endproperty
  a_level_cap: assert property (p_level_cap)
    else $error("level event not pended");

  sequence s_unmapped;
    rif.acc_stb && !is_mapped(rif.adr);
  endsequence
  property p_bus_err;
    s_unmapped |=> irq_status_reg[event_router_pkg::IRQ_BUS_ERR_BIT];
  endproperty
  a_bus_err: assert property (p_bus_err)
    else $error("unmapped access not flagged");

  property p_req_or;
    vic_req_o == (event_fwd_o != 18'h00000);
  endproperty
  a_req_or: assert property (p_req_or)
    else $error("request mismatch");

  property p_upper_zero;
    wb_ack_o |-> (wb_dat_o[31:18] == 14'h0000);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper bits set");

endmodule // event_router
`default_nettype wire

// ==== testbench/vic_model.sv ====
// Behavioural vectored interrupt controller taking forwarded requests
`timescale 1ns/1ns
`default_nettype none
module vic_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        vic_req_i,
  input  wire logic [17:0] event_fwd_i,
  output var  logic [17:0] seen_o,
  output var  logic [15:0] bad_cnt_o
);
  // ****************************************************************
  // Request intake: accept every forwarded level, flag a request line
  // that disagrees with the forwarded vector
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seen_o    <= 18'h00000;
      bad_cnt_o <= 16'h0000;
    end else begin
      seen_o <= seen_o | event_fwd_i;
      if (vic_req_i !== (|event_fwd_i)) begin
        bad_cnt_o <= bad_cnt_o + 16'h0001;
      end
    end
  end
endmodule // vic_model
`default_nettype wire

// ==== testbench/event_router_status_enable_bench.sv ====
// Register level tests of the event router with a controller model
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  err_total++; $display("CHECK FAILED t=%0t got %h exp %h", \
  $time, got, exp); end end
module event_router_status_enable_bench;
  logic        clk_i;
  logic        rstn_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic [17:0] evt;
  logic        vic_req;
  logic [17:0] fwd;
  logic        irq;
  logic [17:0] seen;
  logic [15:0] bad_cnt;
  int          err_total;
  int          n_checks;

  event_router u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .events_i(evt),
    .vic_req_o(vic_req), .event_fwd_o(fwd), .irq_o(irq)
  );

  vic_model u_vic (
    .clk_i(clk_i), .rstn_i(rstn_i), .vic_req_i(vic_req),
    .event_fwd_i(fwd), .seen_o(seen), .bad_cnt_o(bad_cnt)
  );

  always #4 clk_i = ~clk_i;

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      $display("CHECK FAILED t=%0t no bus answer", $time);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, q);
    `CHK(q, e)
  endtask

  task automatic drive_evt(input logic [17:0] v);
    @(posedge clk_i);
    evt <= v;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic test_end(input string name);
    $display("test %s done, errors so far %0d", name, err_total);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    conclude();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    clk_i = 1'b0; rstn_i = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 12'h000; sel = 4'hF; wdat = 32'h00000000; evt = 18'h00000;
    err_total = 0; n_checks = 0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    // Reset values and the reserved slot
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000000);
    rd_chk(event_router_pkg::OFS_ENABLE, 32'h0003FFFF);
    rd_chk(event_router_pkg::OFS_POLARITY, 32'h0003C00F);
    rd_chk(event_router_pkg::OFS_TRIGGER, 32'h0003FFFF);
    rd_chk(event_router_pkg::OFS_RAW_STATUS, 32'h00000000);
    rd_chk(event_router_pkg::OFS_RESERVED, 32'h00000000);
    rd_chk(event_router_pkg::OFS_IRQ_STATUS, 32'h00000000);
    `CHK(vic_req, 1'b0)
    test_end("reset");
    // Software set and clear of pending bits
    wr(event_router_pkg::OFS_PENDING_SET, 32'h00000005);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000005);
    `CHK(fwd, 18'h00005)
    `CHK(vic_req, 1'b1)
    wr(event_router_pkg::OFS_PENDING_CLEAR, 32'h00000001);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000004);
    wr(event_router_pkg::OFS_PENDING_CLEAR, 32'h00000004);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000000);
    `CHK(vic_req, 1'b0)
    test_end("set_clear");
    // Enable gating and latched edges
    wr(event_router_pkg::OFS_ENABLE_CLEAR, 32'h00000002);
    rd_chk(event_router_pkg::OFS_ENABLE, 32'h0003FFFD);
    drive_evt(18'h00003);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000001);
    `CHK(fwd, 18'h00001)
    rd_chk(event_router_pkg::OFS_RAW_STATUS, 32'h00000003);
    wr(event_router_pkg::OFS_PENDING_CLEAR, 32'h00000001);
    repeat (3) @(posedge clk_i);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000000);
    rd_chk(event_router_pkg::OFS_RAW_STATUS, 32'h00000002);
    wr(event_router_pkg::OFS_ENABLE_SET, 32'h00000002);
    rd_chk(event_router_pkg::OFS_ENABLE, 32'h0003FFFF);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000000);
    drive_evt(18'h00000);
    test_end("enable");
    // Level mode and low sense on event 0
    wr(event_router_pkg::OFS_TRIGGER, 32'h0003FFFE);
    rd_chk(event_router_pkg::OFS_TRIGGER, 32'h0003FFFE);
    drive_evt(18'h00001);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000001);
    drive_evt(18'h00000);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000000);
    wr(event_router_pkg::OFS_POLARITY, 32'h0003C00E);
    repeat (2) @(posedge clk_i);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000001);
    wr(event_router_pkg::OFS_POLARITY, 32'h0003C00F);
    wr(event_router_pkg::OFS_TRIGGER, 32'h0003FFFF);
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000000);
    test_end("level");
    // Event capture coinciding with a clear of the same bit
    wr(event_router_pkg::OFS_PENDING_SET, 32'h00000004);
    fork
      wr(event_router_pkg::OFS_PENDING_CLEAR, 32'h00000004);
      begin
        @(posedge clk_i);
        evt <= 18'h00004;
      end
    join
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000004);
    wr(event_router_pkg::OFS_PENDING_CLEAR, 32'h00000004);
    drive_evt(18'h00000);
    test_end("priority");
    // Block interrupt: unmapped access, capture, mask and clear
    wr(event_router_pkg::OFS_IRQ_STATUS, 32'h00000003);
    wr(event_router_pkg::OFS_IRQ_MASK, 32'h00000003);
    `CHK(irq, 1'b0)
    rd_chk(12'hE00, 32'h00000000);
    rd_chk(event_router_pkg::OFS_IRQ_STATUS, 32'h00000002);
    `CHK(irq, 1'b1)
    wr(event_router_pkg::OFS_IRQ_MASK, 32'h00000000);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    wr(event_router_pkg::OFS_IRQ_MASK, 32'h00000001);
    drive_evt(18'h00008);
    `CHK(irq, 1'b1)
    rd_chk(event_router_pkg::OFS_IRQ_STATUS, 32'h00000003);
    wr(event_router_pkg::OFS_IRQ_STATUS, 32'h00000003);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b0)
    rd_chk(event_router_pkg::OFS_PENDING, 32'h00000008);
    test_end("irq");
    // Controller model view
    `CHK(bad_cnt, 16'h0000)
    `CHK(seen, 18'h0000D)
    test_end("model");
    conclude();
  end
endmodule // event_router_status_enable_bench
`default_nettype wire
